// File: rtl/fpm_front_panel.sv
// fpm_front_panel: two-digit display, two-button menu and apb slave
//
// Behaviour
// - drive two digits, read two buttons
// - show device status after control power-up
// - sixty seconds idle returns to status
// - device error overrides display at once
// - left opens menu, scrolls, never changes settings
// - value entry: left/right set each digit
// - right selects; held right keeps descending
// - both buttons: up, accept, five-second flash
// - press while flashing aborts the save
// - unaborted flash commits value at end
// - action only after one-second hold, except the abort of a flash
// - top menu: parameter, address, fieldbus entries
// - mains on, control off: ready indication
// - safe torque and enable: stage ready
// - start enabled: technology ready indication
// - failed action alternates error and number
// - hex values and device error codes, decimal failure numbers in parameter menu
//
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module fpm_front_panel #(
   parameter logic [35:0] HOLD_CYCLES     = fpm_pkg::HOLD_CYCLES,
   parameter logic [35:0] IDLE_CYCLES     = fpm_pkg::IDLE_CYCLES,
   parameter logic [35:0] FLASH_CYCLES    = fpm_pkg::FLASH_CYCLES,
   parameter logic [35:0] BLINK_CYCLES    = fpm_pkg::BLINK_CYCLES,
   parameter logic [35:0] DEBOUNCE_CYCLES = fpm_pkg::DEBOUNCE_CYCLES
) (
   // clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_reset,
   // buttons
   input  wire logic                  i_left_button,
   input  wire logic                  i_right_button,
   // drive state
   input  wire logic                  i_mains_ready,
   input  wire logic                  i_safe_torque_release,
   input  wire logic                  i_power_stage_enable_input,
   input  wire logic                  i_start_enabled,
   input  wire logic                  i_device_error,
   input  wire logic [7:0]            i_device_error_code,
   // display
   output fpm_pkg::fpm_digits_t       o_digits,
   // storage commit
   output logic                       o_commit_valid,
   output fpm_pkg::fpm_commit_t       o_commit,
   // apb slave
   input  wire logic                  i_psel,
   input  wire logic                  i_penable,
   input  wire logic                  i_pwrite,
   input  wire logic [7:0]            i_paddr,
   input  wire logic [31:0]           i_pwdata,
   output logic [31:0]                o_prdata,
   output logic                       o_pready,
   output logic                       o_pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // buttons
   logic       left_level;
   logic       right_level;
   logic [1:0] btn_prev;

   fpm_debounce #(.DB_CYCLES(DEBOUNCE_CYCLES)) u_left_db (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_raw   (i_left_button),
      .o_level (left_level)
   );

   fpm_debounce #(.DB_CYCLES(DEBOUNCE_CYCLES)) u_right_db (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .i_raw   (i_right_button),
      .o_level (right_level)
   );

   wire [1:0] btn         = {left_level, right_level};
   wire       btn_changed = btn != btn_prev;
   wire       any_press   = |(btn & ~btn_prev);

   ////////////////////////////////////////////////////////////////////////////
   // timers
   logic [35:0] hold_cnt;
   logic [35:0] idle_cnt;
   logic [35:0] flash_cnt;
   logic [35:0] blink_cnt;
   logic        blink_on;

   // a held combination repeats every hold period, so held right keeps descending
   wire hold_done = (btn != 2'b00) && !btn_changed
                    && (hold_cnt == HOLD_CYCLES - 36'h1);
   wire act_left  = hold_done && (btn == 2'b10);
   wire act_right = hold_done && (btn == 2'b01);
   wire act_both  = hold_done && (btn == 2'b11);
   wire act_any   = hold_done;
   wire idle_out  = (btn == 2'b00) && (idle_cnt == IDLE_CYCLES - 36'h1);
   wire flash_end = flash_cnt == FLASH_CYCLES - 36'h1;
   wire blink_end = blink_cnt == BLINK_CYCLES - 36'h1;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         btn_prev  <= 2'b00;
         hold_cnt  <= 36'h0;
         idle_cnt  <= 36'h0;
         blink_cnt <= 36'h0;
         blink_on  <= 1'b1;
      end else begin
         btn_prev  <= btn;
         hold_cnt  <= (btn == 2'b00 || btn_changed || hold_done) ? 36'h0 : hold_cnt + 36'h1;
         idle_cnt  <= (btn != 2'b00 || idle_out) ? 36'h0 : idle_cnt + 36'h1;
         blink_cnt <= blink_end ? 36'h0 : blink_cnt + 36'h1;
         blink_on  <= blink_end ? !blink_on : blink_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // menu state
   fpm_pkg::fpm_mode_t mode;
   fpm_pkg::fpm_mode_t next_mode;
   logic [1:0]         entry;
   logic [1:0]         next_entry;
   logic [7:0]         edit;
   logic [7:0]         next_edit;
   logic               commit_now;
   logic [7:0]         setting [3];

   always_comb begin
      next_mode  = mode;
      next_entry = entry;
      next_edit  = edit;
      commit_now = 1'b0;
      case (mode)
         fpm_pkg::FPM_STATUS: begin
            if (act_left) begin
               next_mode  = fpm_pkg::FPM_TOP;
               next_entry = fpm_pkg::ENTRY_PARAM;
            end
         end
         fpm_pkg::FPM_TOP: begin
            if (act_left) begin
               next_entry = (entry == fpm_pkg::ENTRY_LAST) ? fpm_pkg::ENTRY_PARAM
                                                          : entry + 2'h1;
            end else if (act_right) begin
               next_mode = fpm_pkg::FPM_VALUE;
               next_edit = setting[entry];
            end else if (act_both) begin
               next_mode = fpm_pkg::FPM_STATUS;
            end
         end
         fpm_pkg::FPM_VALUE: begin
            if (act_left) begin
               next_edit = {edit[7:4] + 4'h1, edit[3:0]};
            end else if (act_right) begin
               next_edit = {edit[7:4], edit[3:0] + 4'h1};
            end else if (act_both) begin
               next_mode = fpm_pkg::FPM_FLASH;
            end
         end
         fpm_pkg::FPM_FLASH: begin
            if (any_press) begin
               next_mode = fpm_pkg::FPM_TOP;
            end else if (flash_end) begin
               next_mode  = fpm_pkg::FPM_TOP;
               commit_now = 1'b1;
            end
         end
         default: begin
            next_mode = fpm_pkg::FPM_STATUS;
         end
      endcase
      // device error wins; an unfinished edit is discarded
      if (i_device_error || (idle_out && mode != fpm_pkg::FPM_FLASH)) begin
         next_mode  = fpm_pkg::FPM_STATUS;
         commit_now = 1'b0;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mode      <= fpm_pkg::FPM_STATUS;
         entry     <= fpm_pkg::ENTRY_PARAM;
         edit      <= 8'h00;
         flash_cnt <= 36'h0;
      end else begin
         mode      <= next_mode;
         entry     <= next_entry;
         edit      <= next_edit;
         flash_cnt <= (mode == fpm_pkg::FPM_FLASH) ? flash_cnt + 36'h1 : 36'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // apb decode
   wire        apb_setup  = i_psel && !i_penable;
   wire        apb_write  = i_psel && i_penable && o_pready && i_pwrite;
   wire        hit_status = i_paddr == fpm_pkg::ADDR_STATUS;
   wire        hit_set0   = i_paddr == fpm_pkg::ADDR_SETTING0;
   wire        hit_set1   = i_paddr == fpm_pkg::ADDR_SETTING1;
   wire        hit_set2   = i_paddr == fpm_pkg::ADDR_SETTING2;
   wire        hit_opfail = i_paddr == fpm_pkg::ADDR_OPFAIL;
   wire        hit_any    = hit_status || hit_set0 || hit_set1 || hit_set2 || hit_opfail;
   wire        wr_opfail  = apb_write && hit_opfail;
   wire [1:0]  wr_index   = hit_set0 ? 2'h0 : (hit_set1 ? 2'h1 : 2'h2);
   wire        wr_setting = apb_write && (hit_set0 || hit_set1 || hit_set2);

   ////////////////////////////////////////////////////////////////////////////
   // stored settings and operator failure report
   logic [7:0] opfail_num;
   logic       opfail_active;

   // a panel commit in the same cycle as a software write wins
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         for (int k = 0; k < 3; k++) begin
            setting[k] <= fpm_pkg::SETTING_RESET;
         end
      end else if (commit_now) begin
         setting[entry] <= edit;
      end else if (wr_setting) begin
         setting[wr_index] <= i_pwdata[7:0];
      end
   end

   // a fresh report in the same cycle as an acknowledging press wins
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         opfail_num    <= 8'h00;
         opfail_active <= 1'b0;
      end else if (wr_opfail) begin
         opfail_num    <= i_pwdata[7:0];
         opfail_active <= i_pwdata[fpm_pkg::OPF_ACTIVE_BIT];
      end else if (act_any) begin
         opfail_active <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // display selection
   wire [3:0] status_num = (i_start_enabled && i_safe_torque_release
                            && i_power_stage_enable_input) ? fpm_pkg::DS_TECH_READY
                         : (i_safe_torque_release && i_power_stage_enable_input)
                            ? fpm_pkg::DS_STAGE_READY
                         : i_mains_ready ? fpm_pkg::DS_READY_ON
                         : fpm_pkg::DS_NOT_READY;
   wire        in_param  = (mode != fpm_pkg::FPM_STATUS) && (entry == fpm_pkg::ENTRY_PARAM);
   wire [7:0]  fail_show = in_param ? fpm_pkg::fpm_to_dec(opfail_num) : opfail_num;
   wire [7:0]  err_num   = i_device_error ? i_device_error_code : fail_show;
   wire [15:0] err_segs  = blink_on ? {fpm_pkg::SEG_E, fpm_pkg::SEG_R}
                         : {fpm_pkg::fpm_hex_seg(err_num[7:4]),
                            fpm_pkg::fpm_hex_seg(err_num[3:0])};
   wire [15:0] edit_segs = {fpm_pkg::fpm_hex_seg(edit[7:4]),
                            fpm_pkg::fpm_hex_seg(edit[3:0])};
   wire [15:0] dp_segs   = {fpm_pkg::SEG_DP, fpm_pkg::SEG_DP};
   wire [15:0] entry_segs = (entry == fpm_pkg::ENTRY_PARAM)   ? {fpm_pkg::SEG_P, fpm_pkg::SEG_A}
                          : (entry == fpm_pkg::ENTRY_NETADDR) ? {fpm_pkg::SEG_I, fpm_pkg::SEG_P}
                          : {fpm_pkg::SEG_F, fpm_pkg::SEG_B};
   logic [15:0] next_segs;

   // the flash shows the value with blinking points, dark on off phases
   always_comb begin
      next_segs = {fpm_pkg::SEG_S, fpm_pkg::fpm_hex_seg(status_num)};
      if (i_device_error || opfail_active) begin
         next_segs = err_segs;
      end else begin
         case (mode)
            fpm_pkg::FPM_STATUS: next_segs = {fpm_pkg::SEG_S, fpm_pkg::fpm_hex_seg(status_num)};
            fpm_pkg::FPM_TOP:    next_segs = entry_segs;
            fpm_pkg::FPM_VALUE:  next_segs = edit_segs;
            fpm_pkg::FPM_FLASH:  next_segs = blink_on ? (edit_segs | dp_segs) : 16'h0000;
            default:             next_segs = 16'h0000;
         endcase
      end
   end

   wire [31:0] status_word = {23'h0,
                              opfail_active,
                              i_device_error,
                              mode == fpm_pkg::FPM_FLASH,
                              entry,
                              2'h0,
                              2'(mode)};
   wire [31:0] next_rdata = hit_status ? status_word
                          : hit_set0   ? {24'h0, setting[0]}
                          : hit_set1   ? {24'h0, setting[1]}
                          : hit_set2   ? {24'h0, setting[2]}
                          : hit_opfail ? {23'h0, opfail_active, opfail_num}
                          : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // registered outputs
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_digits       <= '0;
         o_commit_valid <= 1'b0;
         o_commit       <= '0;
      end else begin
         o_digits       <= next_segs;
         o_commit_valid <= commit_now;
         o_commit       <= commit_now ? {entry, edit} : o_commit;
      end
   end

   // no wait state: every access phase answers in its first cycle
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_pready  <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata  <= 32'h0;
      end else begin
         o_pready  <= apb_setup;
         o_pslverr <= apb_setup && !hit_any;
         o_prdata  <= apb_setup ? next_rdata : 32'h0;
      end
   end

endmodule

// File: rtl/fpm_pkg.sv
// fpm_pkg: constants, types and helpers for the front panel menu controller
package fpm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam longint CLK_KHZ          = 100000;
   localparam longint HOLD_TIME_MS     = 1000;
   localparam longint IDLE_TIME_MS     = 60000;
   localparam longint FLASH_TIME_MS    = 5000;
   localparam longint BLINK_TIME_MS    = 500;
   localparam longint DEBOUNCE_TIME_MS = 10;
   localparam int     CNT_W            = 36;

   // 60 s at 100 MHz passes 2^32, hence 64-bit products and 36-bit counters
   localparam logic [CNT_W-1:0] HOLD_CYCLES     = CNT_W'(HOLD_TIME_MS * CLK_KHZ);
   localparam logic [CNT_W-1:0] IDLE_CYCLES     = CNT_W'(IDLE_TIME_MS * CLK_KHZ);
   localparam logic [CNT_W-1:0] FLASH_CYCLES    = CNT_W'(FLASH_TIME_MS * CLK_KHZ);
   localparam logic [CNT_W-1:0] BLINK_CYCLES    = CNT_W'(BLINK_TIME_MS * CLK_KHZ);
   localparam logic [CNT_W-1:0] DEBOUNCE_CYCLES = CNT_W'(DEBOUNCE_TIME_MS * CLK_KHZ);

   ////////////////////////////////////////////////////////////////////////////
   // apb register map (byte addresses)
   localparam int         ADDR_W        = 8;
   localparam logic [7:0] ADDR_STATUS   = 8'h00;
   localparam logic [7:0] ADDR_SETTING0 = 8'h04;
   localparam logic [7:0] ADDR_SETTING1 = 8'h08;
   localparam logic [7:0] ADDR_SETTING2 = 8'h0C;
   localparam logic [7:0] ADDR_OPFAIL   = 8'h10;

   // status fields
   localparam int ST_MODE_LSB  = 0;
   localparam int ST_ENTRY_LSB = 4;
   localparam int ST_FLASH_BIT = 6;
   localparam int ST_ERROR_BIT = 7;
   localparam int ST_FAIL_BIT  = 8;
   // operator failure fields
   localparam int OPF_ACTIVE_BIT = 8;

   // reset values
   localparam logic [7:0] SETTING_RESET = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // menu entries
   localparam logic [1:0] ENTRY_PARAM   = 2'h0;
   localparam logic [1:0] ENTRY_NETADDR = 2'h1;
   localparam logic [1:0] ENTRY_BUS     = 2'h2;
   localparam logic [1:0] ENTRY_LAST    = 2'h2;

   // device status numbers shown after the s
   localparam logic [3:0] DS_NOT_READY   = 4'h1;
   localparam logic [3:0] DS_READY_ON    = 4'h2;
   localparam logic [3:0] DS_STAGE_READY = 4'h3;
   localparam logic [3:0] DS_TECH_READY  = 4'h5;

   ////////////////////////////////////////////////////////////////////////////
   // segment patterns, bit 7 decimal point, bits 6..0 g..a
   localparam logic [7:0] SEG_P     = 8'h73;
   localparam logic [7:0] SEG_A     = 8'h77;
   localparam logic [7:0] SEG_I     = 8'h30;
   localparam logic [7:0] SEG_F     = 8'h71;
   localparam logic [7:0] SEG_B     = 8'h7C;
   localparam logic [7:0] SEG_E     = 8'h79;
   localparam logic [7:0] SEG_R     = 8'h50;
   localparam logic [7:0] SEG_S     = 8'h6D;
   localparam logic [7:0] SEG_BLANK = 8'h00;
   localparam logic [7:0] SEG_DP    = 8'h80;

   typedef enum {FPM_STATUS, FPM_TOP, FPM_VALUE, FPM_FLASH} fpm_mode_t;

   typedef struct packed {
      logic [1:0] entry;
      logic [7:0] value;
   } fpm_commit_t;

   typedef struct packed {
      logic [7:0] left;
      logic [7:0] right;
   } fpm_digits_t;

   function automatic logic [7:0] fpm_hex_seg(input logic [3:0] nib);
      logic [7:0] s;
      s = 8'h00;
      case (nib)
         4'h0: s = 8'h3F;
         4'h1: s = 8'h06;
         4'h2: s = 8'h5B;
         4'h3: s = 8'h4F;
         4'h4: s = 8'h66;
         4'h5: s = 8'h6D;
         4'h6: s = 8'h7D;
         4'h7: s = 8'h07;
         4'h8: s = 8'h7F;
         4'h9: s = 8'h6F;
         4'hA: s = 8'h77;
         4'hB: s = 8'h7C;
         4'hC: s = 8'h39;
         4'hD: s = 8'h5E;
         4'hE: s = 8'h79;
         default: s = 8'h71;
      endcase
      return s;
   endfunction

   // two decimal digits; values above 99 saturate at 99
   function automatic logic [7:0] fpm_to_dec(input logic [7:0] v);
      logic [7:0] c;
      logic [3:0] tens;
      c = (v > 8'h63) ? 8'h63 : v;
      tens = 4'h0;
      for (int k = 0; k < 9; k++) begin
         if (c >= 8'h0A) begin
            c = c - 8'h0A;
            tens = tens + 4'h1;
         end
      end
      return {tens, c[3:0]};
   endfunction

endpackage

// File: rtl/fpm_debounce.sv
// fpm_debounce: two-flop synchroniser and stability filter for one button
`timescale 1ns/1ns
module fpm_debounce #(
   parameter logic [35:0] DB_CYCLES = fpm_pkg::DEBOUNCE_CYCLES
) (
   // clock and reset
   input  wire logic i_clk,
   input  wire logic i_reset,
   // raw button and clean level
   input  wire logic i_raw,
   output logic      o_level
);

   logic        sync1;
   logic        sync2;
   logic [35:0] stable_cnt;
   wire         differs = sync2 != o_level;
   wire         settled = stable_cnt == DB_CYCLES - 36'h1;

   // sync1 feeds sync2 only, to keep metastability out of the filter
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sync1 <= 1'b0;
         sync2 <= 1'b0;
      end else begin
         sync1 <= i_raw;
         sync2 <= sync1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         stable_cnt <= 36'h0;
         o_level    <= 1'b0;
      end else if (!differs) begin
         stable_cnt <= 36'h0;
      end else if (settled) begin
         stable_cnt <= 36'h0;
         o_level    <= sync2;
      end else begin
         stable_cnt <= stable_cnt + 36'h1;
      end
   end

endmodule

// File: verif/fpm_front_panel_properties.sv
// fpm_checker: port-level assertions on the front panel, bound at the foot
`timescale 1ns/1ns
module fpm_checker #(
   parameter logic [35:0] IDLE_CYCLES  = fpm_pkg::IDLE_CYCLES,
   parameter logic [35:0] FLASH_CYCLES = fpm_pkg::FLASH_CYCLES
) (
   // clock and reset
   input wire logic            i_clk,
   input wire logic            i_reset,
   // buttons and drive state
   input wire logic            i_left_button,
   input wire logic            i_right_button,
   input wire logic            i_device_error,
   // display and commit
   input fpm_pkg::fpm_digits_t o_digits,
   input wire logic            o_commit_valid,
   input fpm_pkg::fpm_commit_t o_commit,
   // apb
   input wire logic            i_psel,
   input wire logic            i_penable,
   input wire logic            o_pready,
   input wire logic            o_pslverr
);
   logic [35:0] idle_cnt;
   logic [3:0]  err_cnt;
   logic        seen_er;
   wire logic   any_btn = i_left_button | i_right_button;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   ////////////////////////////////////////////////////////////////////////////
   // quiet time and error time; error check assumes a short blink period
   always_ff @(posedge i_clk) begin
      if (i_reset || any_btn || i_device_error) idle_cnt <= 36'h0;
      else if (idle_cnt != 36'hFFFFFFFFF) idle_cnt <= idle_cnt + 36'h1;
   end
   always_ff @(posedge i_clk) begin
      if (i_reset || !i_device_error) err_cnt <= 4'h0;
      else if (err_cnt != 4'hF) err_cnt <= err_cnt + 4'h1;
   end
   always_ff @(posedge i_clk) begin
      if (i_reset || !i_device_error) seen_er <= 1'b0;
      else if (o_digits.left == fpm_pkg::SEG_E) seen_er <= 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   sequence s_setup;
      i_psel && !i_penable;
   endsequence
   sequence s_boot;
      $fell(i_reset) && !i_device_error;
   endsequence
   property p_answer;
      s_setup |=> o_pready;
   endproperty
   property p_single;
      o_pready |=> !o_pready;
   endproperty
   property p_slverr;
      o_pslverr |-> o_pready;
   endproperty
   property p_boot;
      s_boot |=> (o_digits.left == fpm_pkg::SEG_S);
   endproperty
   property p_idle;
      (idle_cnt == IDLE_CYCLES + FLASH_CYCLES + 36'h28) |-> (o_digits.left == fpm_pkg::SEG_S);
   endproperty
   property p_error;
      (err_cnt == 4'hC) |-> seen_er;
   endproperty
   property p_pulse;
      o_commit_valid |=> !o_commit_valid;
   endproperty
   property p_hold;
      $changed(o_commit) |-> o_commit_valid;
   endproperty
   property p_abort;
      o_commit_valid |-> !$past(any_btn, 8);
   endproperty
   a_answer: assert property (p_answer) else $error("no apb answer after setup");
   a_single: assert property (p_single) else $error("apb answer longer than one cycle");
   a_slverr: assert property (p_slverr) else $error("slave error without ready");
   a_boot: assert property (p_boot) else $error("no status after reset");
   a_idle: assert property (p_idle) else $error("no return to status when idle");
   a_error: assert property (p_error) else $error("error indication missing");
   a_pulse: assert property (p_pulse) else $error("commit pulse too long");
   a_hold: assert property (p_hold) else $error("commit changed without pulse");
   a_abort: assert property (p_abort) else $error("commit despite press");
endmodule
bind fpm_front_panel fpm_checker #(
   .IDLE_CYCLES (IDLE_CYCLES),
   .FLASH_CYCLES(FLASH_CYCLES)
) fpm_checker_inst (
   .i_clk(i_clk), .i_reset(i_reset), .i_left_button(i_left_button),
   .i_right_button(i_right_button), .i_device_error(i_device_error),
   .o_digits(o_digits), .o_commit_valid(o_commit_valid), .o_commit(o_commit),
   .i_psel(i_psel), .i_penable(i_penable), .o_pready(o_pready), .o_pslverr(o_pslverr)
);

// File: verif/fpm_operator.sv
// fpm_operator: behavioural operator pressing the two buttons
`timescale 1ns/1ns
module fpm_operator (
   // clock
   input wire logic i_clk,
   // buttons, high while pressed
   output logic     o_left_button,
   output logic     o_right_button
);
   initial {o_left_button, o_right_button} = 2'b00;
   // contacts bounce once, then hold n cycles, then let go
   task automatic press(input logic [1:0] btn, input int n);
      @(posedge i_clk);
      {o_left_button, o_right_button} <= btn;
      @(posedge i_clk);
      {o_left_button, o_right_button} <= 2'b00;
      @(posedge i_clk);
      {o_left_button, o_right_button} <= btn;
      repeat (n) @(posedge i_clk);
      {o_left_button, o_right_button} <= 2'b00;
      repeat (8) @(posedge i_clk);
      @(negedge i_clk);
   endtask
endmodule

// File: verif/tb.sv
// tb: self-checking bench for the front panel menu controller
`timescale 1ns/1ns
module tb;
   logic                 i_clk = 1'b0;
   logic                 rst = 1'b1;
   logic                 lb, rb, err = 1'b0, psel = 1'b0, pen = 1'b0, pw = 1'b0;
   logic                 pry, perr, cv, er, ev, nv;
   logic [3:0]           drv = 4'h0;
   logic [7:0]           code = 8'h00, pa = 8'h00;
   logic [31:0]          pwd = 32'h0, prd, rd;
   fpm_pkg::fpm_digits_t dig;
   fpm_pkg::fpm_commit_t cm, last_cm;
   int                   n_commit = 0, bad_count = 0, n_compared = 0, k;
   // {mains, torque, enable, start} beside the right digit; start comes last
   logic [11:0] rows [4] = '{12'h006, 12'h85B, 12'hE4F, 12'hF6D};
   logic [15:0] menu [4] = '{16'h7377, 16'h3073, 16'h717C, 16'h7377};
   always #5 i_clk = ~i_clk;
   fpm_operator op_inst (.i_clk(i_clk), .o_left_button(lb), .o_right_button(rb));
   fpm_front_panel #(.HOLD_CYCLES(36'h14), .IDLE_CYCLES(36'hC8), .FLASH_CYCLES(36'h32),
      .BLINK_CYCLES(36'h5), .DEBOUNCE_CYCLES(36'h3)) fpm_front_panel_inst (
      .i_clk(i_clk), .i_reset(rst), .i_left_button(lb), .i_right_button(rb),
      .i_mains_ready(drv[3]), .i_safe_torque_release(drv[2]),
      .i_power_stage_enable_input(drv[1]), .i_start_enabled(drv[0]),
      .i_device_error(err), .i_device_error_code(code), .o_digits(dig),
      .o_commit_valid(cv), .o_commit(cm), .i_psel(psel), .i_penable(pen), .i_pwrite(pw),
      .i_paddr(pa), .i_pwdata(pwd), .o_prdata(prd), .o_pready(pry), .o_pslverr(perr));
   always @(posedge i_clk) if (cv === 1'b1) begin
      n_commit++;
      last_cm = cm;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge i_clk);
      psel <= 1'b1;
      pw <= w;
      pa <= a;
      pwd <= wd;
      @(posedge i_clk);
      pen <= 1'b1;
      @(posedge i_clk);
      while (pry !== 1'b1) @(posedge i_clk);
      rd = prd;
      er = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   // watch two blink periods for the error word and the number
   task automatic watch(input logic [15:0] num);
      ev = 1'b0;
      nv = 1'b0;
      repeat (12) begin
         @(negedge i_clk);
         if (dig === 16'h7950) ev = 1'b1;
         if (dig === num) nv = 1'b1;
      end
   endtask
   task automatic print_verdict;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge i_clk);
      bad_count++;
      print_verdict();
   end
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (12) @(posedge i_clk);
      chk("reset_digits", 32'(dig), 32'h0);
      rst <= 1'b0;
      @(posedge i_clk);
      @(negedge i_clk);
      chk("boot", 32'(dig), 32'h6D06);
      for (int i = 0; i < 4; i++) begin
         @(posedge i_clk);
         drv <= rows[i][11:8];
         repeat (4) @(negedge i_clk);
         chk("status", 32'(dig), {16'h6D, rows[i][7:0]});
      end
      foreach (menu[i]) begin
         op_inst.press(2'b10, 30);
         chk("menu", 32'(dig), {16'h0, menu[i]});
      end
      op_inst.press(2'b10, 10);
      chk("short", 32'(dig), 32'h7377);
      op_inst.press(2'b01, 30);
      chk("edit", 32'(dig), 32'h3F3F);
      op_inst.press(2'b10, 30);
      op_inst.press(2'b01, 30);
      op_inst.press(2'b01, 30);
      chk("digits", 32'(dig), 32'h065B);
      op_inst.press(2'b11, 30);
      for (k = 0; k < 200 && n_commit == 0; k++) @(posedge i_clk);
      chk("commit", 32'(last_cm), 32'h012);
      apb(1'b0, 8'h04, 32'h0);
      chk("setting0", rd, 32'h12);
      op_inst.press(2'b01, 30);
      chk("reload", 32'(dig), 32'h065B);
      op_inst.press(2'b10, 30);
      op_inst.press(2'b11, 30);
      op_inst.press(2'b01, 10);
      repeat (100) @(posedge i_clk);
      chk("abort", n_commit, 32'h1);
      apb(1'b0, 8'h04, 32'h0);
      chk("kept", rd, 32'h12);
      repeat (300) @(posedge i_clk);
      @(negedge i_clk);
      chk("idle", 32'(dig), 32'h6D6D);
      apb(1'b0, 8'h08, 32'h0);
      chk("setting1_reset", rd, 32'h0);
      apb(1'b1, 8'h08, 32'h5A);
      apb(1'b0, 8'h08, 32'h0);
      chk("setting1", rd, 32'h5A);
      chk("mapped_err", er, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped_err", er, 32'h1);
      chk("unmapped_data", rd, 32'h0);
      apb(1'b1, 8'h10, 32'h111);
      watch(16'h0606);
      chk("opfail_word", ev, 32'h1);
      chk("opfail_hex", nv, 32'h1);
      op_inst.press(2'b10, 30);
      apb(1'b1, 8'h10, 32'h111);
      apb(1'b0, 8'h00, 32'h0);
      chk("status_reg", rd, 32'h101);
      watch(16'h0607);
      chk("opfail_dec", nv, 32'h1);
      @(posedge i_clk);
      err <= 1'b1;
      code <= 8'h2A;
      watch(16'h5B77);
      chk("error_word", ev, 32'h1);
      chk("error_code", nv, 32'h1);
      @(posedge i_clk);
      err <= 1'b0;
      print_verdict();
   end
endmodule
